/* rtl/sss_pkg.sv */
// Package for the serial signal switch: select codes, register offsets, field layouts
// Overview of operation
// - Decoder code 00 zero, 01 analog default
// - Decoder code 10 takes aux input, subcarrier
// - Decoder code 11 takes aux input, plain
// - Modulator code 00 holds zero, carrier off
// - Modulator code 01 holds one, continuous carrier
// - Modulator code 10 default, encoder envelope
// - Modulator code 11 takes aux input, Miller
// - Output codes 000 low, 001 high, 010 envelope
// - Output code 011 raw transmit bit stream
// - Output code 100 regenerated receiver signal
// - Output code 101 subcarrier demodulator; 110/111 reserved
// - Test-route override bit takes aux output
// - Analog end uses modulator 3, output 4
// - Digital end uses output 2, decoder 2
// - Split arrangement only at 106 kBd
// - Two RF paths operated one at a time
package sss_pkg;

  localparam logic [5:0] SSS_ADDR_TRANSMIT_CONTROL   = 6'h11;
  localparam logic [5:0] SSS_ADDR_RECEIVE_CONTROL_TWO = 6'h1E;
  localparam logic [5:0] SSS_ADDR_AUX_OUTPUT_SELECT   = 6'h26;
  localparam logic [5:0] SSS_ADDR_DIGITAL_TEST_SELECT = 6'h3D;

  localparam int SSS_MOD_SEL_LSB   = 0;
  localparam int SSS_DEC_SEL_LSB   = 0;
  localparam int SSS_AUX_SEL_LSB   = 0;
  localparam int SSS_OVERRIDE_BIT  = 7;

  localparam logic [1:0] SSS_DEC_ZERO    = 2'h0;
  localparam logic [1:0] SSS_DEC_ANALOG  = 2'h1;
  localparam logic [1:0] SSS_DEC_AUX_SUB = 2'h2;
  localparam logic [1:0] SSS_DEC_AUX_MAN = 2'h3;

  localparam logic [1:0] SSS_MOD_ZERO    = 2'h0;
  localparam logic [1:0] SSS_MOD_ONE     = 2'h1;
  localparam logic [1:0] SSS_MOD_ENVELOPE = 2'h2;
  localparam logic [1:0] SSS_MOD_AUX     = 2'h3;

  localparam logic [2:0] SSS_AUX_LOW      = 3'h0;
  localparam logic [2:0] SSS_AUX_HIGH     = 3'h1;
  localparam logic [2:0] SSS_AUX_ENVELOPE = 3'h2;
  localparam logic [2:0] SSS_AUX_RAW_TX   = 3'h3;
  localparam logic [2:0] SSS_AUX_RECEIVER = 3'h4;
  localparam logic [2:0] SSS_AUX_SUBDEMOD = 3'h5;

  localparam logic [1:0] SSS_DEC_RESET = SSS_DEC_ANALOG;
  localparam logic [1:0] SSS_MOD_RESET = SSS_MOD_ENVELOPE;
  localparam logic [2:0] SSS_AUX_RESET = SSS_AUX_LOW;

endpackage : sss_pkg

/* rtl/sss_link_if.sv */
// Interface joining the auxiliary serial pins of two reader ends
`timescale 1ns/100ps
interface sss_link_if;
  logic analog_to_digital;
  logic digital_to_analog;

  modport analog_end
  (
    input  digital_to_analog,
    output analog_to_digital
  );
  modport digital_end
  (
    input  analog_to_digital,
    output digital_to_analog
  );
endinterface : sss_link_if

/* rtl/sss_switch.sv */
// Serial signal switch of the device acting as analog front end
`timescale 1ns/100ps
module sss_switch
(
  input  wire logic           clk_in,
  input  wire logic           rst_b_in,
  sss_link_if.analog_end      link,
  input  wire logic           reg_wr_in,
  input  wire logic [5:0]     reg_addr_in,
  input  wire logic [7:0]     reg_wdata_in,
  output logic      [7:0]     reg_rdata_out,
  input  wire logic           envelope_in,
  input  wire logic           raw_tx_in,
  input  wire logic           receiver_in,
  input  wire logic           subdemod_in,
  input  wire logic           analog_rx_in,
  input  wire logic           test_route_in,
  output logic                decoder_data_out,
  output logic                modulator_data_out
);

  typedef struct packed {
    logic [1:0] mod_sel;
    logic [1:0] dec_sel;
    logic [2:0] aux_sel;
    logic       override;
    logic       aux_meta;
    logic       aux_sync;
    logic       aux_out;
    logic       dec_out;
    logic       mod_out;
    logic [7:0] rdata;
  } sss_state_t;

  sss_state_t st_reg;
  sss_state_t st_next;

  function automatic logic sss_hit(input logic [5:0] a, input logic [5:0] r);
    sss_hit = (a == r);
  endfunction : sss_hit

  always_comb
  begin
    st_next = st_reg;
    st_next.aux_meta = link.digital_to_analog;
    st_next.aux_sync = st_reg.aux_meta;
    if (reg_wr_in && sss_hit(reg_addr_in, sss_pkg::SSS_ADDR_TRANSMIT_CONTROL))
    begin
      st_next.mod_sel = reg_wdata_in[sss_pkg::SSS_MOD_SEL_LSB +: 2];
    end
    if (reg_wr_in && sss_hit(reg_addr_in, sss_pkg::SSS_ADDR_RECEIVE_CONTROL_TWO))
    begin
      st_next.dec_sel = reg_wdata_in[sss_pkg::SSS_DEC_SEL_LSB +: 2];
    end
    if (reg_wr_in && sss_hit(reg_addr_in, sss_pkg::SSS_ADDR_AUX_OUTPUT_SELECT))
    begin
      st_next.aux_sel = reg_wdata_in[sss_pkg::SSS_AUX_SEL_LSB +: 3];
    end
    if (reg_wr_in && sss_hit(reg_addr_in, sss_pkg::SSS_ADDR_DIGITAL_TEST_SELECT))
    begin
      st_next.override = reg_wdata_in[sss_pkg::SSS_OVERRIDE_BIT];
    end
    case (st_reg.dec_sel)
      sss_pkg::SSS_DEC_ZERO:    st_next.dec_out = 1'b0;
      sss_pkg::SSS_DEC_ANALOG:  st_next.dec_out = analog_rx_in;
      sss_pkg::SSS_DEC_AUX_SUB: st_next.dec_out = st_reg.aux_sync;
      sss_pkg::SSS_DEC_AUX_MAN: st_next.dec_out = st_reg.aux_sync;
      default:                  st_next.dec_out = 1'b0;
    endcase
    case (st_reg.mod_sel)
      sss_pkg::SSS_MOD_ZERO:     st_next.mod_out = 1'b0;
      sss_pkg::SSS_MOD_ONE:      st_next.mod_out = 1'b1;
      sss_pkg::SSS_MOD_ENVELOPE: st_next.mod_out = envelope_in;
      sss_pkg::SSS_MOD_AUX:      st_next.mod_out = st_reg.aux_sync;
      default:                   st_next.mod_out = 1'b0;
    endcase
    if (st_reg.override)
    begin
      st_next.aux_out = test_route_in;
    end
    else
    begin
      case (st_reg.aux_sel)
        sss_pkg::SSS_AUX_LOW:      st_next.aux_out = 1'b0;
        sss_pkg::SSS_AUX_HIGH:     st_next.aux_out = 1'b1;
        sss_pkg::SSS_AUX_ENVELOPE: st_next.aux_out = envelope_in;
        sss_pkg::SSS_AUX_RAW_TX:   st_next.aux_out = raw_tx_in;
        sss_pkg::SSS_AUX_RECEIVER: st_next.aux_out = receiver_in;
        sss_pkg::SSS_AUX_SUBDEMOD: st_next.aux_out = subdemod_in;
        default:                   st_next.aux_out = 1'b0;
      endcase
    end
    // Registered readback, one cycle behind the address
    st_next.rdata = 8'h00;
    case (reg_addr_in)
      sss_pkg::SSS_ADDR_TRANSMIT_CONTROL:    st_next.rdata[sss_pkg::SSS_MOD_SEL_LSB +: 2] = st_reg.mod_sel;
      sss_pkg::SSS_ADDR_RECEIVE_CONTROL_TWO: st_next.rdata[sss_pkg::SSS_DEC_SEL_LSB +: 2] = st_reg.dec_sel;
      sss_pkg::SSS_ADDR_AUX_OUTPUT_SELECT:   st_next.rdata[sss_pkg::SSS_AUX_SEL_LSB +: 3] = st_reg.aux_sel;
      sss_pkg::SSS_ADDR_DIGITAL_TEST_SELECT: st_next.rdata[sss_pkg::SSS_OVERRIDE_BIT] = st_reg.override;
      default:                               st_next.rdata = 8'h00;
    endcase
    if (!rst_b_in)
    begin
      st_next = '0;
      st_next.mod_sel = sss_pkg::SSS_MOD_RESET;
      st_next.dec_sel = sss_pkg::SSS_DEC_RESET;
      st_next.aux_sel = sss_pkg::SSS_AUX_RESET;
    end
  end

  always_ff @(posedge clk_in)
  begin
    st_reg <= st_next;
  end

  // analog end drives its selected aux output out
  assign link.analog_to_digital = st_reg.aux_out;
  assign reg_rdata_out          = st_reg.rdata;
  assign decoder_data_out       = st_reg.dec_out;
  assign modulator_data_out     = st_reg.mod_out;

endmodule : sss_switch

/* rtl/sss_digital_end.sv */
// Digital-front-end partner: routes its envelope out and aux input to its decoder
`timescale 1ns/100ps
module sss_digital_end
(
  input  wire logic           clk_in,
  input  wire logic           rst_b_in,
  sss_link_if.digital_end     link,
  input  wire logic           envelope_in,
  input  wire logic           split_enable_in,
  output logic                decoder_data_out
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic dec;
    logic aux;
  } sss_dig_state_t;

  sss_dig_state_t st_reg;
  sss_dig_state_t st_next;

  always_comb
  begin
    st_next      = st_reg;
    st_next.meta = link.analog_to_digital;
    st_next.sync = st_reg.meta;
    st_next.dec  = st_reg.sync;
    // link idles low unless 106 kBd split enabled
    st_next.aux  = split_enable_in & envelope_in;
    if (!rst_b_in)
    begin
      st_next = '0;
    end
  end

  always_ff @(posedge clk_in)
  begin
    st_reg <= st_next;
  end

  assign link.digital_to_analog = st_reg.aux;
  assign decoder_data_out       = st_reg.dec;

endmodule : sss_digital_end

/* verif/sss_link_asserts.sv */
// Checker on the aux link of the analog end
`timescale 1ns/100ps
module sss_link_asserts
(
  input wire logic       clk_in,
  input wire logic       rst_b_in,
  input wire logic       reg_wr_in,
  input wire logic [5:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       envelope_in,
  input wire logic       raw_tx_in,
  input wire logic       receiver_in,
  input wire logic       subdemod_in,
  input wire logic       test_route_in,
  input wire logic       analog_to_digital
);
  // Mirror of override and output select
  logic [3:0] cfg_reg;
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
      cfg_reg <= 4'h0;
    else
    begin
      // Override lives in its own register, apart from the select
      if (reg_wr_in && reg_addr_in == sss_pkg::SSS_ADDR_AUX_OUTPUT_SELECT)
        cfg_reg[2:0] <= reg_wdata_in[sss_pkg::SSS_AUX_SEL_LSB +: 3];
      if (reg_wr_in && reg_addr_in == sss_pkg::SSS_ADDR_DIGITAL_TEST_SELECT)
        cfg_reg[3] <= reg_wdata_in[sss_pkg::SSS_OVERRIDE_BIT];
    end
  end
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  a_aux_low: assert property (cfg_reg == 4'h0 |=> !analog_to_digital) else $error("aux low");
  a_aux_high: assert property (cfg_reg == 4'h1 |=> analog_to_digital) else $error("aux high");
  a_aux_env: assert property (cfg_reg == 4'h2 |=> analog_to_digital == $past(envelope_in)) else $error("env");
  a_aux_raw: assert property (cfg_reg == 4'h3 |=> analog_to_digital == $past(raw_tx_in)) else $error("raw");
  a_aux_rcv: assert property (cfg_reg == 4'h4 |=> analog_to_digital == $past(receiver_in)) else $error("rcv");
  a_aux_sub: assert property (cfg_reg == 4'h5 |=> analog_to_digital == $past(subdemod_in)) else $error("sub");
  a_aux_rsvd: assert property (cfg_reg[3:1] == 3'h3 |=> !analog_to_digital) else $error("rsvd");
  a_test_route: assert property (cfg_reg[3] |=> analog_to_digital == $past(test_route_in)) else $error("ovr");
endmodule : sss_link_asserts

/* verif/serial_signal_switch_tb.sv */
// Testbench joining analog and digital ends
`timescale 1ns/100ps
module serial_signal_switch_tb;
  typedef struct packed {logic [5:0] a; logic [7:0] d; logic [6:0] s; logic [3:0] e;} sss_row_t;
  logic clk_in, rst_b_in, reg_wr_in, envelope_in, raw_tx_in, receiver_in, subdemod_in, analog_rx_in;
  logic test_route_in, dig_env, decoder_data_out, modulator_data_out, dig_dec, split_en;
  logic [5:0] reg_addr_in;
  logic [7:0] reg_wdata_in, reg_rdata_out;
  int n_mismatch = 0;
  int checks_done = 0;
  // Rows: address, data, sources, expected {dig dec, aux out, mod, dec}
  sss_row_t rows [20] = '{'{6'h11,8'h00,7'h11,4'h1}, '{6'h11,8'h01,7'h00,4'h2}, '{6'h11,8'h02,7'h01,4'h2},
    '{6'h1E,8'h00,7'h10,4'h0}, '{6'h26,8'h02,7'h01,4'hE}, '{6'h26,8'h03,7'h02,4'hC}, '{6'h26,8'h04,7'h04,4'hC},
    '{6'h26,8'h05,7'h08,4'hC}, '{6'h26,8'h06,7'h3E,4'h0}, '{6'h26,8'h07,7'h3E,4'h0}, '{6'h26,8'h01,7'h00,4'hC},
    '{6'h3D,8'h80,7'h00,4'h0}, '{6'h26,8'h00,7'h20,4'hC}, '{6'h3D,8'h00,7'h04,4'h0},
    '{6'h26,8'h04,7'h04,4'hC}, '{6'h11,8'h03,7'h40,4'h2}, '{6'h1E,8'h02,7'h40,4'h3},
    '{6'h1E,8'h03,7'h40,4'h3}, '{6'h1E,8'h01,7'h10,4'h1}, '{6'h20,8'h00,7'h10,4'h1}};
  sss_link_if link();
  sss_switch i_sss_switch(.clk_in, .rst_b_in, .link(link), .reg_wr_in, .reg_addr_in, .reg_wdata_in,
    .reg_rdata_out, .envelope_in, .raw_tx_in, .receiver_in, .subdemod_in, .analog_rx_in, .test_route_in,
    .decoder_data_out, .modulator_data_out);
  sss_digital_end i_sss_digital_end(.clk_in, .rst_b_in, .link(link), .envelope_in(dig_env),
    .split_enable_in(split_en), .decoder_data_out(dig_dec));
  sss_link_asserts i_sss_link_asserts(.clk_in, .rst_b_in, .reg_wr_in, .reg_addr_in, .reg_wdata_in,
    .envelope_in, .raw_tx_in, .receiver_in, .subdemod_in, .test_route_in,
    .analog_to_digital(link.analog_to_digital));
  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out;
    if (n_mismatch == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
  task automatic settle_check(input logic [3:0] exp);
    repeat (8) @(posedge clk_in);
    #1;
    check({4'h0, dig_dec, link.analog_to_digital, modulator_data_out, decoder_data_out}, {4'h0, exp});
  endtask : settle_check
  task automatic put_row(input sss_row_t r);
    @(posedge clk_in);
    {reg_wr_in, reg_addr_in, reg_wdata_in} <= {1'b1, r.a, r.d};
    {dig_env, test_route_in, analog_rx_in, subdemod_in, receiver_in, raw_tx_in, envelope_in} <= r.s;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    settle_check(r.e);
  endtask : put_row
  task automatic read_check(input logic [5:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    reg_addr_in <= a;
    repeat (2) @(posedge clk_in);
    #1;
    check(reg_rdata_out, exp);
  endtask : read_check
  initial
  begin
    rst_b_in = 1'b0;
    reg_wr_in = 1'b0;
    reg_addr_in = 6'h11;
    reg_wdata_in = 8'h00;
    {dig_env, test_route_in, analog_rx_in, subdemod_in, receiver_in, raw_tx_in, envelope_in} = 7'h00;
    split_en = 1'b1;
    repeat (6) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    #1;
    check({6'h0, reg_rdata_out[1:0]}, 8'h02);
    foreach (rows[i])
    begin
      put_row(rows[i]);
    end
    check(reg_rdata_out, 8'h00);
    read_check(6'h11, 8'h03);
    read_check(6'h26, 8'h04);
    read_check(6'h1E, 8'h01);
    read_check(6'h3D, 8'h00);
    @(posedge clk_in);
    rst_b_in <= 1'b0;
    {dig_env, test_route_in, analog_rx_in, subdemod_in, receiver_in, raw_tx_in, envelope_in} <= 7'h11;
    repeat (6) @(posedge clk_in);
    rst_b_in <= 1'b1;
    settle_check(4'h3);
    @(posedge clk_in);
    split_en <= 1'b0;
    put_row({6'h1E, 8'h02, 7'h51, 4'h2});
    @(posedge clk_in);
    split_en <= 1'b1;
    settle_check(4'h3);
    close_out();
  end
endmodule : serial_signal_switch_tb
